/* flash_bus_cycle.sv */
// One flash bus cycle: write or read with enable pulse timing
`timescale 1ns/1ps
module flash_bus_cycle
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Request
	input  wire logic        start,
	input  cyc_kind_t        kind,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	// Flash pins
	output logic [20:0]      f_addr,
	output logic [15:0]      f_dq_out,
	output logic             f_dq_oe,
	input  wire logic [15:0] f_dq_in,
	output logic             f_ce_n,
	output logic             f_we_n,
	output logic             f_oe_n
);

	// ========================================
	// Phase counter
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SETUP = 2'b01,
		PH_PULSE = 2'b10,
		PH_HOLD  = 2'b11
	} phase_t;

	phase_t      ph_q, ph_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        rd_q, rd_d;
	logic        done_d;
	logic [15:0] rdata_d;
	logic [20:0] fa_d;
	logic [15:0] fdo_d;
	logic        oe_d, ce_d, we_d, foe_d;

	always_comb begin
		ph_d = ph_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		done_d = 1'b0;
		rdata_d = rdata;
		fa_d = f_addr;
		fdo_d = f_dq_out;
		oe_d = f_dq_oe;
		ce_d = f_ce_n;
		we_d = f_we_n;
		foe_d = f_oe_n;
		case (ph_q)
			PH_IDLE: begin
				if (start) begin
					rd_d = (kind == CYC_READ);
					fa_d = addr;
					fdo_d = wdata;
					oe_d = (kind == CYC_WRITE);
					ph_d = PH_SETUP;
				end
			end
			PH_SETUP: begin
				// Address settles, then CE and the strobe fall; last fall latches
				ce_d = 1'b0;
				we_d = rd_q;
				foe_d = ~rd_q;
				cnt_d = 4'(PULSE_CYC);
				ph_d = PH_PULSE;
			end
			PH_PULSE: begin
				if (cnt_q <= 4'h1) begin
					// WE rises before CE so data latches at WE's rise
					we_d = 1'b1;
					foe_d = 1'b1;
					if (rd_q)
						rdata_d = f_dq_in;
					ph_d = PH_HOLD;
				end else
					cnt_d = cnt_q - 4'h1;
			end
			PH_HOLD: begin
				ce_d = 1'b1;
				oe_d = 1'b0;
				done_d = 1'b1;
				ph_d = PH_IDLE;
			end
			default: ph_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ph_q <= PH_IDLE;
			cnt_q <= 4'h0;
			rd_q <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			f_addr <= 21'h00_0000;
			f_dq_out <= 16'h0000;
			f_dq_oe <= 1'b0;
			f_ce_n <= 1'b1;
			f_we_n <= 1'b1;
			f_oe_n <= 1'b1;
		end else begin
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			done <= done_d;
			rdata <= rdata_d;
			f_addr <= fa_d;
			f_dq_out <= fdo_d;
			f_dq_oe <= oe_d;
			f_ce_n <= ce_d;
			f_we_n <= we_d;
			f_oe_n <= foe_d;
		end
	end

endmodule : flash_bus_cycle

/* flash_dev_model.sv */
// Behavioural model of the parallel flash device
`timescale 1ns/1ps
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [8:0] PROT_SECT = 9'h1F0,
	parameter int         PROG_RD   = 4,
	parameter int         ERASE_RD  = 12
)
(
	// Flash pins
	input  wire logic [20:0] f_addr,
	input  wire logic [15:0] f_dq_in,
	input  wire logic        f_ce_n,
	input  wire logic        f_we_n,
	input  wire logic        f_oe_n,
	output logic [15:0]      dev_dq,
	output logic             rb_low,
	// Fault control
	input  wire logic        stuck
);
	logic [15:0] mem [logic [20:0]];
	logic [20:0] a;
	logic [15:0] d, v = 16'h0000;
	logic [8:0]  es;
	logic        pv, tog = 0, id = 0, susp = 0, ers = 0, stk = 0, wa = 0;
	int          cyc = 0, busy = 0, erem = 0;
	assign rb_low = busy > 0 || stk;
	assign dev_dq = (!f_oe_n && !f_ce_n) ? v : ~v;
	// ========================================
	// Bus edges
	always @(negedge f_we_n or negedge f_ce_n)
		if (!f_we_n && !f_ce_n) begin
			a = f_addr;
			wa = 1'b1;
		end
	always @(posedge f_we_n or posedge f_ce_n)
		if (wa) begin
			wa = 1'b0;
			d = f_dq_in;
			cmd();
		end
	always @(negedge f_oe_n or negedge f_ce_n)
		if (!f_oe_n && !f_ce_n && f_we_n)
			rd();
	// ========================================
	// Command decode
	task automatic cmd;
		if (cyc == 3) begin
			cyc = 0;
			pv = d[7];
			ers = 1'b0;
			if (stuck)
				stk = 1'b1;
			else if (a[20:12] == PROT_SECT)
				busy = 2;
			else begin
				mem[a] = d;
				busy = PROG_RD;
			end
		end else if (d[7:0] == 8'hF0) begin
			cyc = 0;
			{id, stk} = 2'b00;
		end else if (d[7:0] == 8'hB0) begin
			if (busy > 0 && ers) begin
				erem = busy;
				busy = 0;
				susp = 1'b1;
			end
		end else if (d[7:0] == 8'h30 && cyc != 6) begin
			if (susp) begin
				busy = erem;
				{susp, ers} = 2'b01;
			end
		end else if (d[7:0] == 8'h98) begin
			if (busy == 0 && a[10:0] == 11'h055)
				id = 1'b1;
		end else
			case (cyc)
			0, 4: cyc = (d[7:0] == 8'hAA && a[10:0] == 11'h555) ? cyc + 1 : 0;
			1, 5: cyc = (d[7:0] == 8'h55 && a[10:0] == 11'h2AA) ? cyc + 1 : 0;
			2: cyc = (d[7:0] == 8'hA0) ? 3 : (d[7:0] == 8'h80) ? 4 : 0;
			default: begin
				cyc = 0;
				es = a[20:12];
				busy = ERASE_RD;
				ers = 1'b1;
			end
			endcase
	endtask : cmd
	// ========================================
	// Read data and status
	task automatic rd;
		v = mem.exists(f_addr) ? mem[f_addr] : 16'hFFFF;
		if (busy > 0 || stk) begin
			tog = !tog;
			v = {8'h00, !ers && !pv, tog, stk, 5'h00};
			if (busy > 0)
				busy = busy - 1;
			if (busy == 0 && ers) begin
				ers = 1'b0;
				foreach (mem[k])
					if (k[20:12] == es)
						mem[k] = 16'hFFFF;
			end
		end else if (susp && f_addr[20:12] == es)
			v = 16'h0080;
		else if (id)
			v = 16'h0051;
	endtask : rd
endmodule : flash_dev_model

/* flash_host_ctrl.sv */
// Host controller sequencing commands and status polling of a NOR flash
// Function
// - Command sequence cycles are writes, except array and ident reads.
// - Reset command is written after timeout or to leave ident mode; the code writes it only when software issues OP_RESET.
// - Bypass program only after bypass entry; bypass reset exits it.
// - After polling bit matches, a further read confirms all data bits; the code ends the wait on a stable toggle bit and an equal re-read instead.
// - Status reads are addressed to the busy bank.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int POLL_MAX = POLL_LIMIT
)
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Software register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Flash pins
	output logic [20:0]      f_addr,
	output logic [15:0]      f_dq_out,
	output logic             f_dq_oe,
	input  wire logic [15:0] f_dq_in,
	output logic             f_ce_n,
	output logic             f_we_n,
	output logic             f_oe_n,
	input  wire logic        ready_busy_n
);

	// ========================================
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_CMD   = 3'b001,
		S_WAIT  = 3'b010,
		S_POLL  = 3'b011,
		S_CONF  = 3'b100,
		S_DONE  = 3'b101
	} state_t;

	state_t      st_q, st_d;
	logic [2:0]  op_q, op_d;
	logic [20:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] rres_q, rres_d;
	logic [15:0] prev_q, prev_d;
	logic [2:0]  step_q, step_d;
	logic        have_prev_q, have_prev_d;
	logic        susp_q, susp_d;
	logic        erasing_q, erasing_d;
	logic        fail_q, fail_d;
	logic        refused_q, refused_d;
	logic        susp_req_q, susp_req_d;
	logic        susp_ask;
	logic [12:0] polls_q, polls_d;
	logic        rb_s1_q, rb_s2_q;
	logic        start;
	cyc_kind_t   kind;
	logic [20:0] c_addr;
	logic [15:0] c_data;
	logic        cyc_done;
	logic [15:0] cyc_rdata;
	logic [31:0] rdata_d;
	logic        busy;

	assign busy = (st_q != S_IDLE);

	// Suspend request taken while an erase is being issued or polled
	assign susp_ask = reg_wr && reg_addr == REG_CTRL
		&& reg_wdata[2:0] == OP_SUSPEND && busy
		&& op_q == OP_SECT_ERASE;

	// ========================================
	// Command word sequence for each operation
	function automatic logic [2:0] seq_len(input logic [2:0] op);
		case (op)
			OP_PROGRAM:    seq_len = 3'd4;
			OP_SECT_ERASE: seq_len = 3'd6;
			OP_QUERY:      seq_len = 3'd1;
			OP_READ:       seq_len = 3'd0;
			default:       seq_len = 3'd1;
		endcase
	endfunction : seq_len

	always_comb begin
		c_addr = ADDR_UNLOCK1;
		c_data = CMD_UNLOCK1;
		kind = CYC_WRITE;
		case (op_q)
			OP_PROGRAM: begin
				case (step_q)
					3'd0: c_data = CMD_UNLOCK1;
					3'd1: begin
						c_addr = ADDR_UNLOCK2;
						c_data = CMD_UNLOCK2;
					end
					3'd2: c_data = CMD_PROGRAM;
					default: begin
						c_addr = addr_q;
						c_data = wdata_q;
					end
				endcase
			end
			OP_SECT_ERASE: begin
				case (step_q)
					3'd1, 3'd4: begin
						c_addr = ADDR_UNLOCK2;
						c_data = CMD_UNLOCK2;
					end
					3'd2: c_data = CMD_ERASE;
					3'd5: begin
						c_addr = {addr_q[20:12], 12'h000};
						c_data = CMD_SECTOR;
					end
					default: c_data = CMD_UNLOCK1;
				endcase
			end
			OP_RESET: begin
				c_addr = addr_q;
				c_data = CMD_RESET;
			end
			OP_SUSPEND: begin
				c_addr = addr_q;
				c_data = CMD_SUSPEND;
			end
			OP_RESUME: begin
				c_addr = addr_q;
				c_data = CMD_RESUME;
			end
			OP_QUERY: begin
				c_addr = ADDR_QUERY;
				c_data = CMD_QUERY;
			end
			default: begin
				c_addr = addr_q;
				kind = CYC_READ;
			end
		endcase
		if (st_q == S_POLL || st_q == S_CONF) begin
			c_addr = addr_q;
			kind = CYC_READ;
		end
	end

	// ========================================
	// Sequencer
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rres_d = rres_q;
		prev_d = prev_q;
		step_d = step_q;
		have_prev_d = have_prev_q;
		susp_d = susp_q;
		erasing_d = erasing_q;
		fail_d = fail_q;
		refused_d = refused_q;
		polls_d = polls_q;
		susp_req_d = susp_req_q | susp_ask;
		start = 1'b0;
		if (reg_wr && !busy) begin
			if (reg_addr == REG_ADDR)
				addr_d = reg_wdata[20:0];
			if (reg_addr == REG_WDATA)
				wdata_d = reg_wdata[15:0];
		end
		case (st_q)
			S_IDLE: begin
				if (reg_wr && reg_addr == REG_CTRL) begin
					op_d = reg_wdata[2:0];
					refused_d = 1'b0;
					step_d = 3'd0;
					if ((reg_wdata[2:0] == OP_SUSPEND
							&& !(erasing_q && !susp_q))
						|| (reg_wdata[2:0] == OP_RESUME && !susp_q)
						|| (reg_wdata[2:0] == OP_QUERY && erasing_q)) begin
						refused_d = 1'b1;
					end else begin
						fail_d = 1'b0;
						st_d = S_CMD;
					end
				end
			end
			S_CMD: begin
				start = 1'b1;
				st_d = S_WAIT;
			end
			S_WAIT: begin
				if (cyc_done) begin
					step_d = step_q + 3'd1;
					if (step_q + 3'd1 < seq_len(op_q))
						st_d = S_CMD;
					else if (op_q == OP_PROGRAM
						|| op_q == OP_SECT_ERASE
						|| op_q == OP_RESUME) begin
						// Resumed erase is polled to its end
						if (op_q == OP_RESUME) begin
							susp_d = 1'b0;
							op_d = OP_SECT_ERASE;
						end
						erasing_d = (op_q == OP_SECT_ERASE) | erasing_q;
						have_prev_d = 1'b0;
						polls_d = 13'h0000;
						st_d = S_POLL;
					end else begin
						rres_d = cyc_rdata;
						if (op_q == OP_SUSPEND)
							susp_d = 1'b1;
						if (op_q == OP_RESET && !susp_q)
							erasing_d = 1'b0;
						st_d = S_DONE;
					end
				end
			end
			S_POLL: begin
				start = 1'b1;
				st_d = S_CONF;
			end
			S_CONF: begin
				if (cyc_done) begin
					rres_d = cyc_rdata;
					prev_d = cyc_rdata;
					have_prev_d = 1'b1;
					polls_d = polls_q + 13'h0001;
					// Stable toggle bit ends the wait; confirmed by re-read
					if (have_prev_q && cyc_rdata[TOGGLE_BIT]
							== prev_q[TOGGLE_BIT] && cyc_rdata
							== prev_q) begin
						if (op_q == OP_PROGRAM && cyc_rdata[POLL_BIT]
								!= wdata_q[POLL_BIT])
							fail_d = 1'b1;
						if (op_q == OP_SECT_ERASE) begin
							erasing_d = susp_q;
							if (!cyc_rdata[POLL_BIT])
								fail_d = 1'b1;
						end
						st_d = S_DONE;
					end else if (cyc_rdata[TIMEOUT_BIT] && have_prev_q
							&& prev_q[TIMEOUT_BIT]) begin
						fail_d = 1'b1;
						st_d = S_DONE;
					end else if (susp_req_q || susp_ask) begin
						op_d = OP_SUSPEND;
						step_d = 3'd0;
						susp_req_d = 1'b0;
						st_d = S_CMD;
					end else if (polls_q >= 13'(POLL_MAX - 1)) begin
						fail_d = 1'b1;
						st_d = S_DONE;
					end else
						st_d = S_POLL;
				end
			end
			S_DONE: begin
				susp_req_d = 1'b0;
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// ========================================
	// Register read port
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL:   rdata_d = {29'h0, op_q};
				REG_ADDR:   rdata_d = {11'h000, addr_q};
				REG_WDATA:  rdata_d = {16'h0000, wdata_q};
				REG_STATUS: rdata_d = {26'h0, ~rb_s2_q, refused_q,
					erasing_q, susp_q, fail_q, busy};
				REG_RDATA:  rdata_d = {16'h0000, rres_q};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= S_IDLE;
			op_q <= 3'h0;
			addr_q <= 21'h00_0000;
			wdata_q <= 16'h0000;
			rres_q <= 16'h0000;
			prev_q <= 16'h0000;
			step_q <= 3'h0;
			have_prev_q <= 1'b0;
			susp_q <= 1'b0;
			erasing_q <= 1'b0;
			fail_q <= 1'b0;
			refused_q <= 1'b0;
			susp_req_q <= 1'b0;
			polls_q <= 13'h0000;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
			reg_rdata <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rres_q <= rres_d;
			prev_q <= prev_d;
			step_q <= step_d;
			have_prev_q <= have_prev_d;
			susp_q <= susp_d;
			erasing_q <= erasing_d;
			fail_q <= fail_d;
			refused_q <= refused_d;
			susp_req_q <= susp_req_d;
			polls_q <= polls_d;
			rb_s1_q <= ready_busy_n;
			rb_s2_q <= rb_s1_q;
			reg_rdata <= rdata_d;
		end
	end

	// ========================================
	// Bus cycle engine
	flash_bus_cycle u_cycle (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.start    (start),
		.kind     (kind),
		.addr     (c_addr),
		.wdata    (c_data),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.f_addr   (f_addr),
		.f_dq_out (f_dq_out),
		.f_dq_oe  (f_dq_oe),
		.f_dq_in  (f_dq_in),
		.f_ce_n   (f_ce_n),
		.f_we_n   (f_we_n),
		.f_oe_n   (f_oe_n)
	);

endmodule : flash_host_ctrl

/* flash_host_ctrl_assertions.sv */
// Port checker for the flash host controller
`timescale 1ns/1ps
module flash_host_ctrl_assertions
	import flash_host_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// Register port
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Flash pins
	input wire logic [20:0] f_addr,
	input wire logic [15:0] f_dq_out,
	input wire logic        f_dq_oe,
	input wire logic        f_ce_n,
	input wire logic        f_we_n,
	input wire logic        f_oe_n,
	input wire logic        ready_busy_n
);
	// ========================================
	// Bus cycle shape
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_write;
		$fell(f_we_n) |-> (!f_we_n && f_dq_oe)[*2]
			##1 (f_we_n && f_dq_oe) ##1 (f_ce_n && !f_dq_oe);
	endproperty
	a_write: assert property (p_write) else $error("write shape");
	property p_read;
		$fell(f_oe_n) |-> (!f_oe_n && !f_dq_oe)[*2] ##1 f_oe_n ##1 f_ce_n;
	endproperty
	a_read: assert property (p_read) else $error("read shape");
	property p_in_ce;
		(!f_we_n || !f_oe_n) |-> !f_ce_n;
	endproperty
	a_in_ce: assert property (p_in_ce) else $error("strobe no ce");
	property p_addr_hold;
		(!f_ce_n && !$past(f_ce_n)) |-> $stable(f_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
	property p_excl;
		!(!f_we_n && !f_oe_n);
	endproperty
	a_excl: assert property (p_excl) else $error("we and oe low");
	property p_unlock;
		(!f_we_n && f_dq_out == CMD_UNLOCK1) |-> f_addr == ADDR_UNLOCK1;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock addr");
	// ========================================
	// Busy pin in status
	property p_busy_lo;
		(!ready_busy_n)[*5] ##0 (reg_rd && reg_addr == REG_STATUS)
			|=> reg_rdata[5];
	endproperty
	a_busy_lo: assert property (p_busy_lo) else $error("busy lost");
	property p_busy_hi;
		(ready_busy_n)[*5] ##0 (reg_rd && reg_addr == REG_STATUS)
			|=> !reg_rdata[5];
	endproperty
	a_busy_hi: assert property (p_busy_hi) else $error("busy stuck");
	c_write: cover property ($fell(f_we_n));
	c_read: cover property ($fell(f_oe_n));
	c_busy: cover property ((!ready_busy_n)[*5]);
endmodule : flash_host_ctrl_assertions

bind flash_host_ctrl flash_host_ctrl_assertions i_chk (.*);

/* flash_host_ctrl_tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_host_ctrl_tb;
	import flash_host_pkg::*;
	logic        ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, stuck = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, s;
	logic [20:0] f_addr, pa;
	logic [15:0] f_dq_out, f_dq_in, dev_dq, pd;
	logic        f_dq_oe, f_ce_n, f_we_n, f_oe_n, ready_busy_n, rb_low;
	logic [15:0] ref_mem [logic [20:0]];
	logic [2:0]  cd [2] = '{OP_SUSPEND, OP_RESUME};
	int          error_cnt = 0, samples_checked = 0;
	assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
	assign f_dq_in = f_dq_oe ? f_dq_out : dev_dq;
	flash_host_ctrl #(.POLL_MAX(32)) i_flash_host_ctrl (.ref_clk, .reset,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .f_addr,
		.f_dq_out, .f_dq_oe, .f_dq_in, .f_ce_n, .f_we_n, .f_oe_n,
		.ready_busy_n);
	flash_dev_model i_flash_dev_model (.f_addr, .f_dq_in, .f_ce_n, .f_we_n,
		.f_oe_n, .dev_dq, .rb_low, .stuck);
	initial forever #25 ref_clk = ~ref_clk;
	initial begin
		#2_000_000;
		error_cnt++;
		stop_test();
	end
	// ========================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		s = reg_rdata;
		@(posedge ref_clk);
	endtask : rd
	task automatic idle;
		for (int i = 0; i < 300; i++) begin
			rd(REG_STATUS);
			if (s[0] === 1'b0)
				return;
		end
		chk("busy", 32'h0000_0000, s);
	endtask : idle
	task automatic op(input logic [2:0] c, input logic [20:0] a,
		input logic [15:0] d);
		wr(REG_ADDR, {11'h000, a});
		wr(REG_WDATA, {16'h0000, d});
		wr(REG_CTRL, {29'h0000_0000, c});
		idle();
	endtask : op
	task automatic rd_arr(input logic [20:0] a);
		op(OP_READ, a, 16'h0000);
		rd(REG_RDATA);
		chk("array", ref_mem.exists(a) ? ref_mem[a] : 32'h0000_FFFF, s);
	endtask : rd_arr
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// ========================================
	// Scenarios
	initial begin
		void'($urandom(32'hD274));
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(REG_STATUS);
		chk("status", 32'h0000_0000, s);
		rd(4'hF);
		chk("unmapped", 32'h0000_0000, s);
		for (int i = 0; i < 6; i++) begin
			pa = {9'h001 + 9'(i % 4), 12'($urandom)};
			pd = 16'($urandom) | 16'h0100;
			op(OP_PROGRAM, pa, pd);
			ref_mem[pa] = pd;
			chk("fail", 32'h0000_0000, {31'h0, s[1]});
			rd_arr(pa);
		end
		op(OP_PROGRAM, 21'h1F_0010, 16'h1234);
		chk("fail", 32'h0000_0001, {31'h0, s[1]});
		rd_arr(21'h1F_0010);
		foreach (cd[i]) begin
			op(cd[i], 21'h00_0000, 16'h0000);
			chk("refused", 32'h0000_0001, {31'h0, s[4]});
		end
		wr(REG_ADDR, 32'h0000_1000);
		wr(REG_CTRL, {29'h0000_0000, OP_SECT_ERASE});
		s = 32'h0000_0000;
		for (int i = 0; i < 200 && s[5] !== 1'b1; i++)
			rd(REG_STATUS);
		chk("flash busy", 32'h0000_0001, {31'h0, s[5]});
		wr(REG_CTRL, {29'h0000_0000, OP_SUSPEND});
		idle();
		chk("suspended", 32'h0000_0001, {31'h0, s[2]});
		op(OP_PROGRAM, 21'h00_2040, 16'h5A5A);
		ref_mem[21'h00_2040] = 16'h5A5A;
		rd_arr(21'h00_2040);
		op(OP_QUERY, 21'h00_0000, 16'h0000);
		chk("refused", 32'h0000_0001, {31'h0, s[4]});
		op(OP_RESUME, 21'h00_1000, 16'h0000);
		chk("status", 32'h0000_0000, {27'h0, s[4:0]});
		foreach (ref_mem[k])
			if (k[20:12] == 9'h001)
				ref_mem[k] = 16'hFFFF;
		foreach (ref_mem[k])
			rd_arr(k);
		op(OP_QUERY, 21'h00_0000, 16'h0000);
		chk("refused", 32'h0000_0000, {31'h0, s[4]});
		op(OP_RESET, 21'h00_0000, 16'h0000);
		rd_arr(21'h00_2040);
		stuck <= 1'b1;
		op(OP_PROGRAM, 21'h00_3000, 16'h1111);
		stuck <= 1'b0;
		chk("fail", 32'h0000_0001, {31'h0, s[1]});
		op(OP_RESET, 21'h00_0000, 16'h0000);
		rd_arr(21'h00_3000);
		stop_test();
	end
endmodule : flash_host_ctrl_tb

/* flash_host_pkg.sv */
// Constants and types for the parallel flash host controller
package flash_host_pkg;

	// ========================================
	// Host command register offsets
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_ADDR      = 4'h1;
	localparam logic [3:0] REG_WDATA     = 4'h2;
	localparam logic [3:0] REG_STATUS    = 4'h3;
	localparam logic [3:0] REG_RDATA     = 4'h4;

	// ========================================
	// Operation codes written to the control register
	localparam logic [2:0] OP_READ       = 3'h1;
	localparam logic [2:0] OP_PROGRAM    = 3'h2;
	localparam logic [2:0] OP_SECT_ERASE = 3'h3;
	localparam logic [2:0] OP_RESET      = 3'h4;
	localparam logic [2:0] OP_SUSPEND    = 3'h5;
	localparam logic [2:0] OP_RESUME     = 3'h6;
	localparam logic [2:0] OP_QUERY      = 3'h7;

	// ========================================
	// Command words and unlock addresses
	localparam logic [15:0] CMD_UNLOCK1  = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;
	localparam logic [15:0] CMD_ERASE    = 16'h0080;
	localparam logic [15:0] CMD_SECTOR   = 16'h0030;
	localparam logic [15:0] CMD_RESET    = 16'h00F0;
	localparam logic [15:0] CMD_SUSPEND  = 16'h00B0;
	localparam logic [15:0] CMD_RESUME   = 16'h0030;
	localparam logic [15:0] CMD_QUERY    = 16'h0098;
	localparam logic [20:0] ADDR_UNLOCK1 = 21'h00_0555;
	localparam logic [20:0] ADDR_UNLOCK2 = 21'h00_02AA;
	localparam logic [20:0] ADDR_QUERY   = 21'h00_0055;

	// ========================================
	// Status bit positions in a flash read word
	localparam int POLL_BIT    = 7;
	localparam int TOGGLE_BIT  = 6;
	localparam int TIMEOUT_BIT = 5;

	// ========================================
	// Bus cycle timing at 20 MHz
	localparam int CLK_NS        = 50;
	localparam int PULSE_NS      = 100;
	localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int POLL_LIMIT    = 4096;
	localparam logic [1:0] SETTLE_CYC = 2'h2;

	// ========================================
	// Bus cycle engine kinds
	typedef enum logic [1:0] {
		CYC_WRITE = 2'b01,
		CYC_READ  = 2'b10
	} cyc_kind_t;

endpackage : flash_host_pkg
